// [design/vfd_pkg.sv]
package vfd_pkg;
  // buffer geometry
  localparam int unsigned BUF_BASE = 32'h0000_0F80;
  localparam int unsigned BUF_LAST = 32'h0000_0FCF;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned ROWS = 16;
  localparam int unsigned COLS = 5;
  localparam int unsigned COL_STRIDE = 16;
  localparam int unsigned OUTS = 37;
  localparam int unsigned LAST_COL_BITS = 5;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned PD_BITS = 5;
  localparam int unsigned PD_FIRST = 32;
  // reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic BLANK_RST = 1'b1;
  // display period, ns, and its cycle count at 50 MHz
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned SLOT_TIME_NS = 1000;
  localparam int unsigned SLOT_CYCLES = (SLOT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 16;
endpackage

// [design/vfd_slot_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module vfd_slot_timer
#(
  parameter int unsigned PERIOD = 50,
  parameter int unsigned CNT_W = 16,
  parameter int unsigned SLOT_W = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [SLOT_W-1:0] last_slot,
  output logic [SLOT_W-1:0] slot,
  output logic slot_end
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [SLOT_W-1:0] slot_q, slot_d;
  logic end_q, end_d;

  // period counter and slot stepping, wraps after last slot
  always_comb
  begin
    cnt_d = cnt_q;
    slot_d = slot_q;
    end_d = 1'b0;
    if (!run)
    begin
      cnt_d = '0;
      slot_d = '0;
    end
    else if (cnt_q == CNT_W'(PERIOD - 1))
    begin
      cnt_d = '0;
      end_d = 1'b1;
      slot_d = (slot_q >= last_slot) ? '0 : slot_q + 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      slot_q <= '0;
      end_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      end_q <= end_d;
    end
  end

  assign slot = slot_q;
  assign slot_end = end_q;
endmodule // vfd_slot_timer
`default_nettype wire

// [design/vfd_display_buffer_scan.sv]
// Functional notes
// - buffer at 0F80H..0FCFH, scanned to driver outputs without software help
// - each buffer bit drives one segment; one lights, zero stays dark
// - five columns of sixteen rows; row n drives slot Tn; last column bits 0-4
// - clearing blank to zero starts the display after setup
// - port output latches reset to zero; kept zero on tube pins
// - fifth port selects driver or port I/O per pin by line select
// - buffer undefined after power-on; software initialises it first
`timescale 1ns/1ps
`default_nettype none
module vfd_display_buffer_scan
  import vfd_pkg::*;
#(
  parameter int unsigned SLOT_PERIOD = vfd_pkg::SLOT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  // data space write/read port
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [vfd_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_hit,
  // display control
  input wire logic display_blank,
  input wire logic [vfd_pkg::SLOT_W-1:0] last_slot,
  input wire logic [vfd_pkg::PD_BITS-1:0] line_select,
  output logic blank_status,
  output logic [vfd_pkg::SLOT_W-1:0] current_slot,
  // port output latches of driver pins
  input wire logic latch_wr,
  input wire logic [2:0] latch_port,
  input wire logic [7:0] latch_wdata,
  // driver pins
  input wire logic [vfd_pkg::OUTS-1:0] pin_in,
  output logic [vfd_pkg::OUTS-1:0] hv_driver_outputs,
  output logic [vfd_pkg::OUTS-1:0] pin_read
);
  import vfd_pkg::*;

  localparam int unsigned DEPTH = ROWS * COLS;
  localparam int unsigned LATCH_PORTS = 5;

  logic [7:0] display_data_buffer [DEPTH];
  logic [7:0] latch_q [LATCH_PORTS];
  logic [7:0] latch_d [LATCH_PORTS];
  logic blank_q, blank_d;
  logic [OUTS-1:0] out_q, out_d;
  logic [OUTS-1:0] sync1_q, sync2_q, read_q;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic [SLOT_W-1:0] slot;
  logic [OUTS-1:0] drive_sel;
  logic in_buf;
  logic [ADDR_W-1:0] offs;
  logic [6:0] idx;
  logic [OUTS-1:0] row_bits;
  logic [OUTS-1:0] latch_bits;

  // address decode of the buffer window
  assign in_buf = (mem_addr >= ADDR_W'(BUF_BASE)) && (mem_addr <= ADDR_W'(BUF_LAST));
  assign offs = mem_addr - ADDR_W'(BUF_BASE);
  assign idx = offs[6:0];

  // pins below the fifth port always drive; fifth port pins follow their line select bit
  assign drive_sel = {line_select, {PD_FIRST{1'b1}}};

  // buffer storage, no reset: contents undefined until software fills it
  always_ff @(posedge clk)
  begin
    if (mem_wr && in_buf)
    begin
      display_data_buffer[idx] <= mem_wdata;
    end
  end

  // read path
  always_comb
  begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (mem_rd && in_buf)
    begin
      rdata_d = display_data_buffer[idx];
      hit_d = 1'b1;
    end
  end

  // gather the row for the current slot, column c row s
  always_comb
  begin
    row_bits = '0;
    for (int c = 0; c < COLS; c++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if ((c * 8 + b) < OUTS)
        begin
          row_bits[c * 8 + b] = display_data_buffer[c * COL_STRIDE + int'(slot)][b];
        end
      end
    end
  end

  // port latches, flattened to pin order
  always_comb
  begin
    latch_bits = '0;
    for (int p = 0; p < LATCH_PORTS; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if ((p * 8 + b) < OUTS)
        begin
          latch_bits[p * 8 + b] = latch_q[p][b];
        end
      end
    end
  end

  // latch, blank and output next values
  always_comb
  begin
    for (int p = 0; p < LATCH_PORTS; p++)
    begin
      latch_d[p] = latch_q[p];
    end
    if (latch_wr && (int'(latch_port) < LATCH_PORTS))
    begin
      latch_d[latch_port] = latch_wdata;
    end
    blank_d = display_blank;
    out_d = '0;
    for (int i = 0; i < OUTS; i++)
    begin
      if (!drive_sel[i])
      begin
        out_d[i] = latch_bits[i];
      end
      else
      begin
        out_d[i] = (!blank_q && row_bits[i]) | latch_bits[i];
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < LATCH_PORTS; p++)
      begin
        latch_q[p] <= LATCH_RST;
      end
      blank_q <= BLANK_RST;
      out_q <= '0;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      blank_q <= blank_d;
      out_q <= out_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  // three-flop pin synchroniser for port reads
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      read_q <= '0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      read_q <= sync2_q;
    end
  end

  // slot sequencer runs while not blanked
  vfd_slot_timer #(
    .PERIOD(SLOT_PERIOD),
    .CNT_W(CNT_W),
    .SLOT_W(SLOT_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .run(!blank_q),
    .last_slot(last_slot),
    .slot(slot),
    .slot_end()
  );

  logic [SLOT_W-1:0] slot_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slot_q <= '0;
    end
    else
    begin
      slot_q <= slot;
    end
  end

  assign hv_driver_outputs = out_q;
  assign pin_read = read_q;
  assign mem_rdata = rdata_q;
  assign mem_hit = hit_q;
  assign blank_status = blank_q;
  assign current_slot = slot_q;
endmodule // vfd_display_buffer_scan
`default_nettype wire

// [bench/vfd_display_buffer_scan_props.sv]
`timescale 1ns/1ps
`default_nettype none
module vfd_display_buffer_scan_props
  import vfd_pkg::*;
#(parameter int unsigned SLOT_PERIOD = vfd_pkg::SLOT_CYCLES)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_rd,
  input wire logic [vfd_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_hit,
  input wire logic blank_status,
  input wire logic display_blank,
  input wire logic [vfd_pkg::SLOT_W-1:0] last_slot,
  input wire logic [vfd_pkg::SLOT_W-1:0] current_slot,
  input wire logic [vfd_pkg::OUTS-1:0] pin_in,
  input wire logic [vfd_pkg::OUTS-1:0] pin_read
);
  logic rd_in;
  int unsigned cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // read aimed inside the buffer window
  assign rd_in = mem_rd && mem_addr >= 12'hF80 && mem_addr <= 12'hFCF;
  // cycles since the slot index last moved
  always_ff @(posedge clk or posedge rst)
    if (rst) cnt_q <= 0;
    else cnt_q <= $changed(current_slot) ? 0 : cnt_q + 1;
  sequence blanked_s; blank_status [*4]; endsequence
  sequence step_s; $changed(current_slot) && !blank_status; endsequence
  a_read_hit: assert property (rd_in |=> mem_hit) else $error("no hit");
  a_read_miss: assert property (!rd_in |=> !mem_hit) else $error("false hit");
  a_rdata_idle: assert property (!mem_hit |-> mem_rdata == 8'h00) else $error("stray data");
  a_blank_park: assert property (blanked_s |-> current_slot == 4'h0) else $error("slot runs");
  a_blank_follow: assert property (blank_status == $past(display_blank)) else $error("blank lag");
  a_slot_step: assert property (step_s |-> current_slot ==
    ($past(current_slot) == last_slot ? 4'h0 : $past(current_slot) + 4'h1)) else $error("bad step");
  a_slot_dwell: assert property ($changed(current_slot) && current_slot > 4'h1 |->
    cnt_q == SLOT_PERIOD - 1) else $error("bad dwell");
  a_slot_bound: assert property (current_slot <= last_slot) else $error("slot high");
  a_pin_sync: assert property (pin_read == $past(pin_in, 3)) else $error("pin lag");
endmodule // vfd_display_buffer_scan_props
bind vfd_display_buffer_scan vfd_display_buffer_scan_props #(.SLOT_PERIOD(SLOT_PERIOD)) props_i (.clk, .rst,
  .mem_rd, .mem_addr, .mem_rdata, .mem_hit, .blank_status, .display_blank, .last_slot, .current_slot, .pin_in,
  .pin_read);
`default_nettype wire

// [bench/vfd_tube.sv]
`timescale 1ns/1ps
`default_nettype none
module vfd_tube
(
  input wire logic clk,
  input wire logic [3:0] current_slot,
  input wire logic [36:0] hv_driver_outputs,
  input wire logic [36:0] ext_en,
  input wire logic [36:0] ext_val,
  output logic [36:0] pin_in,
  output logic [36:0] lit [16]
);
  // pulled-down pins read low when nobody drives them
  assign pin_in = hv_driver_outputs | (ext_val & ext_en);
  // segments lit in each slot
  initial lit = '{default: '0};
  always @(posedge clk)
    lit[current_slot] <= hv_driver_outputs;
endmodule // vfd_tube
`default_nettype wire

// [bench/vfd_display_buffer_scan_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module vfd_display_buffer_scan_tb;
  logic clk = 0, rst = 1, mem_wr = 0, mem_rd = 0, display_blank = 1, latch_wr = 0, mem_hit, blank_status;
  logic [11:0] mem_addr = 0;
  logic [7:0] mem_wdata = 0, latch_wdata = 0, mem_rdata;
  logic [3:0] last_slot = 0, current_slot;
  logic [4:0] line_select = 5'h1F;
  logic [2:0] latch_port = 0;
  logic [36:0] ext_en = 0, ext_val = 0, pin_in, hv_driver_outputs, pin_read;
  logic [36:0] lit [16];
  int fail_count = 0, n_tests = 0;
  always #10 clk = ~clk;
  vfd_display_buffer_scan #(.SLOT_PERIOD(4)) uut (.clk, .rst, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_hit, .display_blank, .last_slot, .line_select, .blank_status, .current_slot, .latch_wr, .latch_port,
    .latch_wdata, .pin_in, .hv_driver_outputs, .pin_read);
  vfd_tube tube (.clk, .current_slot, .hv_driver_outputs, .ext_en, .ext_val, .pin_in, .lit);
  task tick(int n); repeat (n) @(posedge clk); #1; endtask
  // column 0 holds the grids: one digit per slot, slot 5 spans two grids
  function automatic logic [7:0] pat(int c, int r);
    return c == 4 ? 8'(r + 1) : c == 0 ? (r == 5 ? 8'h30 : 8'h01 << (r % 8)) : 8'(c * 16 + r + 1);
  endfunction
  function automatic logic [36:0] row(int r);
    return {5'(pat(4, r)), pat(3, r), pat(2, r), pat(1, r), pat(0, r)};
  endfunction
  task rd(logic [11:0] a, logic [7:0] e); mem_rd = 1; mem_addr = a; tick(1); `CHK(mem_rdata, e) endtask
  task lat(int p, logic [7:0] d); latch_wr = 1; latch_port = 3'(p); latch_wdata = d; tick(1); endtask
  task wr(logic [11:0] a, logic [7:0] d); mem_wr = 1; mem_addr = a; mem_wdata = d; tick(1); endtask
  task end_sim;
    $display("checks %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #50us;
    fail_count++;
    end_sim;
  end
  initial
  begin
    tick(4); rst = 0; tick(1);
    `CHK(hv_driver_outputs, 37'h0)
    `CHK(blank_status, 1'h1)
    $display("reset test done");
    for (int i = 0; i < 81; i++)
    begin
      wr(12'hF80 + 12'(i), i < 80 ? pat(i / 16, i % 16) : 8'hFF);
    end
    mem_wr = 0;
    rd(12'hF80, pat(0, 0));
    rd(12'hFCF, pat(4, 15));
    rd(12'hFD0, 8'h00);
    rd(12'hF7F, 8'h00);
    mem_rd = 0;
    $display("buffer test done");
    last_slot = 4'h5; tick(1);
    display_blank = 0; tick(60);
    for (int r = 0; r < 7; r++)
    begin
      `CHK(lit[r], r < 6 ? row(r) : 37'h0)
      `CHK($countones(lit[r][7:0]), r == 5 ? 2 : (r < 5 ? 1 : 0))
    end
    $display("scan test done");
    for (int r = 0; r < 16; r++) wr(12'hF80 + 12'(r), 8'h00);
    mem_wr = 0;
    line_select = 5'h00; lat(4, 8'h15); lat(0, 8'hFF); lat(5, 8'hFF); latch_wr = 0; tick(3);
    `CHK(hv_driver_outputs[36:32], 5'h15)
    `CHK(hv_driver_outputs[15:0], {pat(1, current_slot), 8'hFF})
    lat(0, 8'h00); lat(4, 8'h00); latch_wr = 0; line_select = 5'h1F; tick(2);
    `CHK(hv_driver_outputs[7:0], 8'h00)
    $display("port test done");
    display_blank = 1; tick(5);
    `CHK(hv_driver_outputs, 37'h0)
    `CHK(current_slot, 4'h0)
    ext_en = '1; ext_val = 37'h15_A5A5_0F0F; tick(4);
    `CHK(pin_read, 37'h15_A5A5_0F0F)
    ext_en = '0; tick(4);
    `CHK(pin_read, 37'h0)
    $display("pin test done");
    end_sim;
  end
endmodule // vfd_display_buffer_scan_tb
`default_nettype wire
